// file: logic/spcg_pkg.sv
package spcg_pkg;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [31:0] SYSCTL_BASE        = 32'h400FE000;
  localparam logic [11:0] RUN_GATE_OFFSET    = 12'h108;
  localparam logic [11:0] SLEEP_GATE_OFFSET  = 12'h118;
  localparam logic [11:0] DEEP_GATE_OFFSET   = 12'h128;
  localparam logic [11:0] RUN_CLK_CFG_OFFSET = 12'h060;
  localparam logic [11:0] MODE_OFFSET        = 12'h200;
  localparam logic [11:0] INT_STATUS_OFFSET  = 12'h204;
  localparam logic [11:0] INT_MASK_OFFSET    = 12'h208;

  // ---------------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------------
  localparam int          NUM_PORTS          = 5;
  localparam int          AUTO_GATE_BIT      = 27;
  localparam int          PORT_WIN_SHIFT     = 12;
  localparam logic [4:0]  GATE_RESET         = 5'h00;
  localparam logic [31:0] RUN_CLK_CFG_RESET  = 32'h00000000;
  localparam logic [2:0]  INT_RESET          = 3'h0;
  localparam int          INT_FAULT_BIT      = 0;
  localparam int          INT_MODE_BIT       = 1;
  localparam int          INT_GATE_CHG_BIT   = 2;

  // power mode codes as written to the mode register
  localparam logic [1:0]  MODE_RUN           = 2'h0;
  localparam logic [1:0]  MODE_SLEEP         = 2'h1;
  localparam logic [1:0]  MODE_DEEP          = 2'h2;

  typedef enum logic [2:0] {
    SPCG_RUN   = 3'b001,
    SPCG_SLEEP = 3'b010,
    SPCG_DEEP  = 3'b100
  } spcg_mode_type;

  // register bus request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } spcg_req_type;

  // access toward the gated port units
  typedef struct packed {
    logic [2:0] port;
    logic       valid;
  } spcg_port_acc_type;

endpackage : spcg_pkg

// file: logic/spcg_top.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module spcg_top (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  // register port
  input  wire spcg_pkg::spcg_req_type     req_i,
  output logic [31:0]                     rdata_o,
  output logic                            rerr_o,
  // port unit access check
  input  wire spcg_pkg::spcg_port_acc_type port_acc_i,
  output logic                            port_fault_o,
  // clock enables to port units
  output logic [4:0]                      port_clk_en_o,
  // interrupt
  output logic                            irq_o
);
  import spcg_pkg::*;

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  logic [4:0]    run_port_gate_reg;
  logic [4:0]    sleep_port_gate_reg;
  logic [4:0]    deep_sleep_port_gate_reg;
  logic [31:0]   run_clock_config_reg;
  spcg_mode_type mode;
  logic [2:0]    int_status;
  logic [2:0]    int_mask;

  // -----------------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a,
                               input logic [11:0] off);
    hit = (a == (SYSCTL_BASE + {20'h00000, off}));
  endfunction : hit

  wire logic sel_run   = hit(req_i.addr, RUN_GATE_OFFSET);
  wire logic sel_sleep = hit(req_i.addr, SLEEP_GATE_OFFSET);
  wire logic sel_deep  = hit(req_i.addr, DEEP_GATE_OFFSET);
  wire logic sel_cfg   = hit(req_i.addr, RUN_CLK_CFG_OFFSET);
  wire logic sel_mode  = hit(req_i.addr, MODE_OFFSET);
  wire logic sel_ists  = hit(req_i.addr, INT_STATUS_OFFSET);
  wire logic sel_imsk  = hit(req_i.addr, INT_MASK_OFFSET);
  wire logic sel_any   = sel_run | sel_sleep | sel_deep | sel_cfg |
                         sel_mode | sel_ists | sel_imsk;
  wire logic wr_en     = req_i.wr;
  wire logic rd_en     = req_i.rd;

  // -----------------------------------------------------------------------
  // mode and effective enable selection
  // -----------------------------------------------------------------------
  wire logic auto_gating_select = run_clock_config_reg[AUTO_GATE_BIT];
  logic [4:0] next_clk_en;

  always_comb begin
    case (mode)
      SPCG_SLEEP: begin
        next_clk_en = auto_gating_select ? sleep_port_gate_reg
                                         : run_port_gate_reg;
      end
      SPCG_DEEP: begin
        next_clk_en = auto_gating_select ? deep_sleep_port_gate_reg
                                         : run_port_gate_reg;
      end
      default: begin
        next_clk_en = run_port_gate_reg;
      end
    endcase
  end

  spcg_mode_type next_mode;
  always_comb begin
    case (req_i.wdata[1:0])
      MODE_SLEEP: next_mode = SPCG_SLEEP;
      MODE_DEEP:  next_mode = SPCG_DEEP;
      default:    next_mode = SPCG_RUN;
    endcase
  end

  wire logic acc_fault = port_acc_i.valid &
                         ((port_acc_i.port > 3'h4) |
                          ~port_clk_en_o[port_acc_i.port]);

  // -----------------------------------------------------------------------
  // read data mux
  // -----------------------------------------------------------------------
  logic [31:0] next_rdata;
  assign next_rdata =
    sel_run   ? {27'h0, run_port_gate_reg} :
    sel_sleep ? {27'h0, sleep_port_gate_reg} :
    sel_deep  ? {27'h0, deep_sleep_port_gate_reg} :
    sel_cfg   ? run_clock_config_reg :
    sel_mode  ? {29'h0, mode} :
    sel_ists  ? {29'h0, int_status} :
    sel_imsk  ? {29'h0, int_mask} : 32'h00000000;

  wire logic [2:0] events = {
    wr_en & sel_sleep & (req_i.wdata[4:0] != sleep_port_gate_reg),
    wr_en & sel_mode,
    acc_fault
  };

  // -----------------------------------------------------------------------
  // gating registers
  // -----------------------------------------------------------------------
  // clear on reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_port_gate_reg        <= GATE_RESET;
      sleep_port_gate_reg      <= GATE_RESET;
      deep_sleep_port_gate_reg <= GATE_RESET;
    end else if (wr_en) begin
      if (sel_run)   run_port_gate_reg        <= req_i.wdata[4:0];
      if (sel_sleep) sleep_port_gate_reg      <= req_i.wdata[4:0];
      if (sel_deep)  deep_sleep_port_gate_reg <= req_i.wdata[4:0];
    end
  end

  // configuration and mode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_clock_config_reg <= RUN_CLK_CFG_RESET;
      mode                 <= SPCG_RUN;
      int_mask             <= INT_RESET;
    end else if (wr_en) begin
      if (sel_cfg)  run_clock_config_reg <= req_i.wdata;
      if (sel_mode) mode                 <= next_mode;
      if (sel_imsk) int_mask             <= req_i.wdata[2:0];
    end
  end

  // sticky status, set wins over read clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_status <= INT_RESET;
    end else if (rd_en && sel_ists) begin
      int_status <= events;
    end else begin
      int_status <= int_status | events;
    end
  end

  // -----------------------------------------------------------------------
  // registered outputs
  // -----------------------------------------------------------------------
  // drive unit clock enables
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_clk_en_o <= GATE_RESET;
      port_fault_o  <= 1'b0;
      irq_o         <= 1'b0;
    end else begin
      port_clk_en_o <= next_clk_en;
      port_fault_o  <= acc_fault;
      irq_o         <= |(int_mask & (int_status | events)) &
                       ~(rd_en & sel_ists & ~|(int_mask & events));
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h00000000;
      rerr_o  <= 1'b0;
    end else begin
      rdata_o <= rd_en ? next_rdata : 32'h00000000;
      rerr_o  <= (rd_en | wr_en) & ~sel_any;
    end
  end

endmodule : spcg_top

`default_nettype wire

// file: test/spcg_sva.sv
`timescale 1ns/1ps
`default_nettype none
// timing relations seen at the top ports
module spcg_sva (
  input wire logic                         clk_i,
  input wire logic                         resetn_i,
  input wire spcg_pkg::spcg_req_type       req_i,
  input wire logic [31:0]                  rdata_o,
  input wire logic                         rerr_o,
  input wire spcg_pkg::spcg_port_acc_type  port_acc_i,
  input wire logic                         port_fault_o,
  input wire logic [4:0]                   port_clk_en_o,
  input wire logic                         irq_o
);
  import spcg_pkg::*;
  localparam logic [31:0] SADR = SYSCTL_BASE + 32'(SLEEP_GATE_OFFSET);
  // access aimed at a unit without clock
  wire logic gated = port_acc_i.valid && (port_acc_i.port > 3'h4 ||
    !port_clk_en_o[port_acc_i.port]);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_fault_gated: assert property (gated |=> port_fault_o)
    else $error("no fault for gated port");
  a_no_fault: assert property (port_acc_i.valid && !gated |=> !port_fault_o)
    else $error("fault for clocked port");
  a_fault_cause: assert property (port_fault_o |-> $past(port_acc_i.valid))
    else $error("fault without access");
  a_rsvd_zero: assert property (req_i.rd && req_i.addr == SADR |=>
    rdata_o[31:5] == 27'h0) else $error("upper bits not zero");
  a_sleep_rdback: assert property (req_i.wr && req_i.addr == SADR ##1
    req_i.rd && req_i.addr == SADR |=>
    rdata_o[4:0] == $past(req_i.wdata[4:0], 2)) else $error("readback");
  a_rdata_idle: assert property (!req_i.rd |=> rdata_o == 32'h0)
    else $error("read data outside read");
  a_en_cause: assert property ($changed(port_clk_en_o) |-> $past(req_i.wr, 2))
    else $error("enables moved without write");
  a_sleep_mapped: assert property ((req_i.rd || req_i.wr) &&
    req_i.addr == SADR |=> !rerr_o) else $error("sleep reg unmapped");
  c_fault: cover property (port_fault_o);
  c_irq: cover property (irq_o);
  c_err: cover property (rerr_o);
  c_en_move: cover property ($changed(port_clk_en_o));
endmodule : spcg_sva
bind spcg_top spcg_sva i_sva (.clk_i(clk_i), .resetn_i(resetn_i),
  .req_i(req_i), .rdata_o(rdata_o), .rerr_o(rerr_o),
  .port_acc_i(port_acc_i), .port_fault_o(port_fault_o),
  .port_clk_en_o(port_clk_en_o), .irq_o(irq_o));
`default_nettype wire

// file: test/spcg_port_model.sv
`timescale 1ns/1ps
`default_nettype none
// port unit side, one access per fire
module spcg_port_model (
  input  wire logic                   clk_i,
  input  wire logic                   fire_i,
  input  wire logic [2:0]             port_i,
  output spcg_pkg::spcg_port_acc_type acc_o
);
  import spcg_pkg::*;
  // idle cycles scramble the index
  always_ff @(posedge clk_i) begin
    acc_o <= '{fire_i ? port_i : ~acc_o.port, fire_i};
  end
endmodule : spcg_port_model
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spcg_pkg::*;
  logic clk_i = 1'h0;
  logic resetn_i = 1'h0;
  spcg_req_type req_i = '0;
  logic fire = 1'h0;
  logic [2:0] pidx = 3'h0;
  spcg_port_acc_type acc;
  logic [31:0] rdata_o, sv, rq[$];
  logic rerr_o, port_fault_o, irq_o, rd_d, ac_d, fq[$], eq[$];
  logic [4:0] en_o;
  int fail_count = 0, checks = 0, cyc = 0;
  integer seed = 75710;
  spcg_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
    .rdata_o(rdata_o), .rerr_o(rerr_o), .port_acc_i(acc),
    .port_fault_o(port_fault_o), .port_clk_en_o(en_o), .irq_o(irq_o));
  spcg_port_model i_pm (.clk_i(clk_i), .fire_i(fire), .port_i(pidx),
    .acc_o(acc));
  // clock
  always #5 clk_i = ~clk_i;
  task chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task wr(input logic [11:0] o, input logic [31:0] d);
    @(posedge clk_i);
    req_i <= '{SYSCTL_BASE + 32'(o), d, 1'h1, 1'h0};
  endtask : wr
  task rd(input logic [11:0] o, input logic [31:0] e);
    rq.push_back(e);
    eq.push_back(!(o inside {RUN_GATE_OFFSET, SLEEP_GATE_OFFSET,
      DEEP_GATE_OFFSET, RUN_CLK_CFG_OFFSET, MODE_OFFSET,
      INT_STATUS_OFFSET, INT_MASK_OFFSET}));
    @(posedge clk_i);
    req_i <= '{SYSCTL_BASE + 32'(o), 32'h0, 1'h0, 1'h1};
  endtask : rd
  task idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      req_i <= '0;
    end
  endtask : idle
  // one access per port plus an index past the last port
  task probe(input logic [4:0] en);
    #1;
    chk("clk_en", 32'(en_o), 32'(en));
    for (int p = 0; p < 6; p++) begin
      @(posedge clk_i);
      fire <= 1'h1;
      pidx <= 3'(p);
      fq.push_back(p > 4 || !en[p]);
    end
    @(posedge clk_i);
    fire <= 1'h0;
    idle(3);
  endtask : probe
  // watcher pairs results with the oldest notes, plus hang limit
  always @(posedge clk_i) begin
    if (rd_d === 1'h1) begin
      chk("rdata", rdata_o, rq.pop_front());
      chk("rerr", 32'(rerr_o), 32'(eq.pop_front()));
    end
    if (ac_d === 1'h1) chk("fault", 32'(port_fault_o), 32'(fq.pop_front()));
    rd_d <= req_i.rd;
    ac_d <= acc.valid;
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'h1;
    rd(SLEEP_GATE_OFFSET, 32'h0);
    rd(RUN_GATE_OFFSET, 32'h0);
    rd(12'h300, 32'h0);
    idle(2);
    probe(5'h00);
    wr(INT_MASK_OFFSET, 32'h1);
    sv = $random(seed);
    wr(SLEEP_GATE_OFFSET, sv);
    rd(SLEEP_GATE_OFFSET, sv & 32'h1F);
    wr(RUN_GATE_OFFSET, 32'hFFFFFFE5);
    wr(MODE_OFFSET, 32'(MODE_SLEEP));
    idle(3);
    probe(5'h05);
    wr(RUN_CLK_CFG_OFFSET, 32'h1 << AUTO_GATE_BIT);
    idle(3);
    probe(sv[4:0]);
    // deep sleep takes its own register
    wr(DEEP_GATE_OFFSET, 32'hFFFFFFFA);
    wr(MODE_OFFSET, 32'(MODE_DEEP));
    idle(3);
    probe(5'h1A);
    rd(MODE_OFFSET, 32'h4);
    wr(MODE_OFFSET, 32'(MODE_RUN));
    idle(3);
    probe(5'h05);
    #1;
    chk("irq", 32'(irq_o), 32'h1);
    rd(INT_STATUS_OFFSET, {29'h0, sv[4:0] != 5'h00, 2'h3});
    rd(INT_STATUS_OFFSET, 32'h0);
    idle(3);
    #1;
    chk("irq", 32'(irq_o), 32'h0);
    // reset in mid-run clears written enables
    @(posedge clk_i);
    resetn_i <= 1'h0;
    @(posedge clk_i);
    resetn_i <= 1'h1;
    rd(SLEEP_GATE_OFFSET, 32'h0);
    idle(2);
    probe(5'h00);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
